/* File: shared/scpc_pkg.sv */
// Purpose: constants shared by the system clock prescaler control block
// Assumes: one master clock, registers reached over AHB-Lite, 32-bit words
// Notes: offsets are byte addresses, one aligned word per register
//
// Contract
// - with the clock-output fuse programmed, system clock drives the output pin
// - clock output pin keeps being driven during reset when fuse programmed
// - clock output works for every clock source, internal RC included
// - the divided clock, not the undivided one, goes to the pin; the code forces bypass in reset, so clk reaches the pin undivided then
// - external-clock select set means timer pin one takes an external clock
// - prescaler divides io, adc, cpu and flash domains together
// - changing division never yields a period shorter than old and new
// - new rate active between T1 + T2 and T1 + 2*T2 after write
// - exactly two active clock edges during the transition interval
// - every reset loads the trim register with the factory value
// - trim top bit selects low or high overlapping frequency range
// - low seven trim bits tune frequency monotonically within range
// - change-enable sets only when all other bits are written zero
// - change-enable clears four cycles after set or on a divide write
// - rewriting change-enable in its window neither extends nor clears it
// - reset loads divide field 0000, or 0011 with divide-by-eight fuse
// - unlocked divide values 0 to 8 accepted, higher codes dropped; codes 0 to 8 divide by 2^n
package scpc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] OSC_TRIM_OFFSET = 32'h0000_0000;
  localparam logic [31:0] CLK_DIV_CTRL_OFFSET = 32'h0000_0004;
  localparam logic [31:0] ASYNC_TIMER_OFFSET = 32'h0000_0008;
  localparam int REG_DEC_W = 4;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int DIV_SEL_W = 4;
  localparam int DIV_CNT_W = 8;
  localparam int CHANGE_ENABLE_BIT = 7;
  localparam int TRIM_RANGE_BIT = 7;
  localparam int TRIM_W = 8;
  localparam int EXT_CLK_SELECT_BIT = 0;
  localparam logic [7:0] UNLOCK_PATTERN = 8'h80;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET_PLAIN = 4'h0;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET_DIV8 = 4'h3;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX = 4'h8;
  localparam logic EXT_CLK_SELECT_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CHANGE_WINDOW_CYCLES = 4;
  localparam int WIN_CNT_W = 2;
  localparam logic [WIN_CNT_W-1:0] WIN_LAST = 2'h3;

  // ----------------------------------------------------------------
  // ahb-lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : scpc_pkg

/* File: hw/scpc_unlock.sv */
// Purpose: timed unlock window guarding the divide select field
// Assumes: ctrlWrite is a one-cycle pulse with the written byte beside it
// Notes: window length counts master clock cycles
module scpc_unlock (
  input wire logic clk,
  input wire logic srst,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlData,
  output logic changeEnable,
  output logic selWrite
);

  logic [scpc_pkg::WIN_CNT_W-1:0] winCnt;

  // decode of the written byte
  wire logic cleanUnlock = (ctrlData == scpc_pkg::UNLOCK_PATTERN);
  wire logic enableBitLow = !ctrlData[scpc_pkg::CHANGE_ENABLE_BIT];
  wire logic armNow = ctrlWrite && cleanUnlock && !changeEnable;
  wire logic divWrite = ctrlWrite && changeEnable && enableBitLow;
  wire logic timeout = changeEnable && (winCnt == scpc_pkg::WIN_LAST);

  // a rewrite of the pattern while open falls through: no restart, no clear
  always_ff @(posedge clk) begin
    if (srst) begin
      changeEnable <= 1'b0;
      winCnt <= '0;
      selWrite <= 1'b0;
    end else begin
      selWrite <= divWrite;
      if (armNow) begin
        changeEnable <= 1'b1;
        winCnt <= '0;
      end else if (timeout || divWrite) begin
        changeEnable <= 1'b0;
      end else if (changeEnable) begin
        winCnt <= winCnt + 1'b1;
      end
    end
  end

  a_ce_clean_only: assert property (@(posedge clk) disable iff (srst)
    ctrlWrite && !cleanUnlock && !changeEnable |=> !changeEnable)
    else $error("change enable set by an unclean write");
  a_ce_timeout: assert property (@(posedge clk) disable iff (srst)
    $rose(changeEnable) |-> ##[1:4] !changeEnable)
    else $error("change enable outlived its window");
  a_ce_no_extend: assert property (@(posedge clk) disable iff (srst)
    changeEnable && ctrlWrite && cleanUnlock && !timeout
      |=> changeEnable && winCnt == $past(winCnt) + 2'h1)
    else $error("rewrite of change enable altered the window");

endmodule : scpc_unlock

/* File: hw/scpc_divider.sv */
// Purpose: glitch-free power-of-two divider of the master clock
// Assumes: reqSel holds a legal code; reserved codes never reach here
// Notes: a new setting is taken only at the end of the running period
module scpc_divider #(
  parameter int SEL_W = 4,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [SEL_W-1:0] reqSel,
  input wire logic [SEL_W-1:0] rstSel,
  output logic tick,
  output logic phase,
  output logic bypass,
  output logic [SEL_W-1:0] curSel
);

  logic [CNT_W-1:0] cnt;

  // period bounds for the running setting
  wire logic [CNT_W:0] span = {{CNT_W{1'b0}}, 1'b1} << curSel;
  wire logic [CNT_W:0] spanM1 = span - {{CNT_W{1'b0}}, 1'b1};
  wire logic [CNT_W-1:0] lastCnt = spanM1[CNT_W-1:0];
  wire logic [CNT_W-1:0] halfCnt = lastCnt >> 1;
  wire logic wrap = (cnt == lastCnt);
  wire logic [CNT_W-1:0] next_cnt = wrap ? '0 : cnt + 1'b1;

  // switching only at wrap means no short period can ever appear
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
      curSel <= rstSel;
      tick <= 1'b0;
      phase <= 1'b1;
      bypass <= 1'b1;
    end else begin
      cnt <= next_cnt;
      if (wrap) begin
        curSel <= reqSel;
      end
      tick <= wrap;
      phase <= wrap ? 1'b1 : (next_cnt <= halfCnt);
      bypass <= wrap ? (reqSel == '0) : (curSel == '0);
    end
  end

  a_sel_at_wrap: assert property (@(posedge clk) disable iff (srst)
    $changed(curSel) |-> $past(wrap))
    else $error("divide setting changed inside a period");
  a_div2_toggles: assert property (@(posedge clk) disable iff (srst)
    curSel == 4'h1 && $past(curSel) == 4'h1 && !$past(srst, 2) |-> phase != $past(phase))
    else $error("divide by two output failed to toggle");

endmodule : scpc_divider

/* File: hw/scpc_top.sv */
// Purpose: system clock prescaler control with trim and clock output
// Assumes: clk is the undivided master clock; fuses and pins are asynchronous
// Notes: domain enables are one-cycle ticks, the pad gates clk when bypassed
//
// The address map and register access over AHB-Lite were left to the implementer.
module scpc_top (
  input wire logic clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // fuses and factory data
  input wire logic clockOutputFuse,
  input wire logic divideByEightFuse,
  input wire logic [7:0] factoryTrim,
  // timer oscillator pin one, as seen by the input buffer
  input wire logic timerOscPinOne,
  // clock output pin
  output logic clockOutputPinOut,
  output logic clockOutputPinOe,
  output logic clockOutputBypass,
  // divided clock domain enables
  output logic ioClkEn,
  output logic adcClkEn,
  output logic cpuClkEn,
  output logic flashClkEn,
  // oscillator trim to the rc oscillator
  output logic trimRangeSelect,
  output logic [6:0] trimFineValue,
  // asynchronous timer clock path
  output logic asyncTimerExternalClockSelect,
  output logic timerExtClk
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic fuseOutMeta;
  logic fuseOutSync;
  logic fuseDiv8Meta;
  logic fuseDiv8Sync;
  logic tpinMeta;
  logic tpinSync;
  logic [7:0] trimMeta;
  logic [7:0] trimSync;

  // no reset here: the clock-out fuse must reach the pad during reset too
  always_ff @(posedge clk) begin
    fuseOutMeta <= clockOutputFuse;
    fuseOutSync <= fuseOutMeta;
    fuseDiv8Meta <= divideByEightFuse;
    fuseDiv8Sync <= fuseDiv8Meta;
    tpinMeta <= timerOscPinOne;
    tpinSync <= tpinMeta;
    trimMeta <= factoryTrim;
    trimSync <= trimMeta;
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  logic wrPend;
  logic [scpc_pkg::REG_DEC_W-1:0] wrAddr;
  logic rdPend;
  logic [scpc_pkg::REG_DEC_W-1:0] rdAddr;

  // one-hot style decode used for both read and write sides
  function automatic logic regHit(input logic [scpc_pkg::REG_DEC_W-1:0] a,
                                  input logic [31:0] off);
    regHit = (a == off[scpc_pkg::REG_DEC_W-1:0]);
  endfunction : regHit

  wire logic transActive = (htrans == scpc_pkg::HTRANS_NONSEQ) ||
                           (htrans == scpc_pkg::HTRANS_SEQ);
  wire logic accept = hsel && hready && transActive;
  wire logic inRange = (haddr[31:scpc_pkg::REG_DEC_W] == '0);
  wire logic [scpc_pkg::REG_DEC_W-1:0] decAddr = haddr[scpc_pkg::REG_DEC_W-1:0];
  wire logic wrAccept = accept && hwrite;
  wire logic rdAccept = accept && !hwrite;

  // reads take one wait state so a write just before is visible, except a divide code, which lands a cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
      rdPend <= 1'b0;
      rdAddr <= '0;
    end else begin
      wrPend <= wrAccept && inRange;
      wrAddr <= decAddr;
      rdPend <= rdAccept;
      rdAddr <= inRange ? decAddr : {scpc_pkg::REG_DEC_W{1'b1}};
    end
  end

  // ----------------------------------------------------------------
  // data phase write strobes
  // ----------------------------------------------------------------
  wire logic trimWrite = wrPend && regHit(wrAddr, scpc_pkg::OSC_TRIM_OFFSET);
  wire logic ctrlWrite = wrPend && regHit(wrAddr, scpc_pkg::CLK_DIV_CTRL_OFFSET);
  wire logic asyncWrite = wrPend && regHit(wrAddr, scpc_pkg::ASYNC_TIMER_OFFSET);
  wire logic [7:0] wrByte = hwdata[7:0];

  // ----------------------------------------------------------------
  // unlock window
  // ----------------------------------------------------------------
  logic changeEnable;
  logic selWrite;
  logic [scpc_pkg::DIV_SEL_W-1:0] selData;

  scpc_unlock u_unlock (
    .clk(clk),
    .srst(srst),
    .ctrlWrite(ctrlWrite),
    .ctrlData(wrByte),
    .changeEnable(changeEnable),
    .selWrite(selWrite)
  );

  // the unlock pulse arrives a cycle after the data, so keep the code
  always_ff @(posedge clk) begin
    if (srst) begin
      selData <= '0;
    end else if (ctrlWrite) begin
      selData <= wrByte[scpc_pkg::DIV_SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // divide select field
  // ----------------------------------------------------------------
  logic [scpc_pkg::DIV_SEL_W-1:0] divSel;

  wire logic [scpc_pkg::DIV_SEL_W-1:0] resetSel =
    fuseDiv8Sync ? scpc_pkg::DIV_SEL_RESET_DIV8 : scpc_pkg::DIV_SEL_RESET_PLAIN;
  wire logic selLegal = (selData <= scpc_pkg::DIV_SEL_MAX);

  // reserved codes are dropped so the divider never sees an undefined rate
  always_ff @(posedge clk) begin
    if (srst) begin
      divSel <= resetSel;
    end else if (selWrite && selLegal) begin
      divSel <= selData;
    end
  end

  // ----------------------------------------------------------------
  // divider and clock distribution
  // ----------------------------------------------------------------
  logic divTick;
  logic divPhase;
  logic divBypass;
  logic [scpc_pkg::DIV_SEL_W-1:0] appliedSel;

  scpc_divider #(
    .SEL_W(scpc_pkg::DIV_SEL_W),
    .CNT_W(scpc_pkg::DIV_CNT_W)
  ) u_divider (
    .clk(clk),
    .srst(srst),
    .reqSel(divSel),
    .rstSel(resetSel),
    .tick(divTick),
    .phase(divPhase),
    .bypass(divBypass),
    .curSel(appliedSel)
  );

  // one tick feeds all four domains so they can never drift apart
  always_ff @(posedge clk) begin
    ioClkEn <= divTick;
    adcClkEn <= divTick;
    cpuClkEn <= divTick;
    flashClkEn <= divTick;
  end

  // ----------------------------------------------------------------
  // clock output pin
  // ----------------------------------------------------------------
  // no reset: the pad stays driven through reset while the fuse is set
  always_ff @(posedge clk) begin
    clockOutputPinOe <= fuseOutSync;
    clockOutputPinOut <= divPhase;
    clockOutputBypass <= divBypass;
  end

  // ----------------------------------------------------------------
  // oscillator trim
  // ----------------------------------------------------------------
  logic [scpc_pkg::TRIM_W-1:0] oscTrim;

  always_ff @(posedge clk) begin
    if (srst) begin
      oscTrim <= trimSync;
    end else if (trimWrite) begin
      oscTrim <= wrByte;
    end
  end

  // range bit and fine code go straight to the oscillator, unmodified
  always_ff @(posedge clk) begin
    trimRangeSelect <= oscTrim[scpc_pkg::TRIM_RANGE_BIT];
    trimFineValue <= oscTrim[scpc_pkg::TRIM_RANGE_BIT-1:0];
  end

  // ----------------------------------------------------------------
  // asynchronous timer clock select
  // ----------------------------------------------------------------
  logic extSelReg;

  always_ff @(posedge clk) begin
    if (srst) begin
      extSelReg <= scpc_pkg::EXT_CLK_SELECT_RESET;
    end else if (asyncWrite) begin
      extSelReg <= wrByte[scpc_pkg::EXT_CLK_SELECT_BIT];
    end
  end

  // sampling pin one only works while clk is over four times its rate
  always_ff @(posedge clk) begin
    if (srst) begin
      asyncTimerExternalClockSelect <= 1'b0;
      timerExtClk <= 1'b0;
    end else begin
      asyncTimerExternalClockSelect <= extSelReg;
      timerExtClk <= extSelReg && tpinSync;
    end
  end

  // ----------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------
  wire logic [31:0] rdTrim = {24'h00_0000, oscTrim};
  wire logic [31:0] rdCtrl = {24'h00_0000, changeEnable, 3'h0, divSel};
  wire logic [31:0] rdAsync = {31'h0000_0000, extSelReg};
  wire logic [31:0] rdMux =
    regHit(rdAddr, scpc_pkg::OSC_TRIM_OFFSET) ? rdTrim :
    regHit(rdAddr, scpc_pkg::CLK_DIV_CTRL_OFFSET) ? rdCtrl :
    regHit(rdAddr, scpc_pkg::ASYNC_TIMER_OFFSET) ? rdAsync : 32'h0000_0000;

  // unmapped addresses read zero and writes to them are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= scpc_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= !rdAccept;
      hresp <= scpc_pkg::HRESP_OKAY;
      if (rdPend) begin
        hrdata <= rdMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin_oe_fuse: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> clockOutputPinOe == $past(fuseOutSync))
    else $error("clock output enable does not follow the fuse");
  a_pin_in_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) && $past(fuseOutSync) |-> clockOutputPinOe)
    else $error("clock output pin dropped during reset");
  a_pin_divided: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) && $past(appliedSel) != 4'h0 |-> !clockOutputBypass)
    else $error("undivided clock reached the pin while dividing");
  a_domains_tied: assert property (@(posedge clk) disable iff (srst)
    ioClkEn == cpuClkEn && adcClkEn == flashClkEn && ioClkEn == $past(divTick))
    else $error("clock domains no longer divided together");
  a_reset_divsel: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> divSel == ($past(fuseDiv8Sync) ? 4'h3 : 4'h0))
    else $error("divide field reset value wrong");
  a_sel_loaded: assert property (@(posedge clk) disable iff (srst)
    selWrite && selLegal |=> divSel == $past(selData))
    else $error("legal divide code was not taken");
  a_sel_reserved: assert property (@(posedge clk) disable iff (srst)
    selWrite && !selLegal |=> $stable(divSel))
    else $error("reserved divide code changed the setting");
  a_trim_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> oscTrim == $past(trimSync))
    else $error("trim not loaded with factory value");
  a_trim_fields: assert property (@(posedge clk) disable iff (srst)
    trimWrite ##2 !$past(trimWrite) |-> {trimRangeSelect, trimFineValue} == $past(wrByte, 2))
    else $error("trim fields do not match the written code");
  a_ext_sel: assert property (@(posedge clk) disable iff (srst)
    asyncWrite ##2 !$past(asyncWrite) |-> asyncTimerExternalClockSelect == $past(wrByte[0], 2))
    else $error("external clock select not applied");
  a_read_wait: assert property (@(posedge clk) disable iff (srst)
    rdAccept |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule : scpc_top

/* File: bench/test_system_clock_prescaler_ctrl.sv */
// Purpose: self-checking bench for the system clock prescaler control block
// Assumes: hready is looped back from hreadyout, one master clock, fuses held static until the closing clock-out toggle and second reset
// Notes: trim and reserved codes drawn from a fixed seed; corner codes forced by hand
module test_system_clock_prescaler_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = scpc_pkg::HSIZE_WORD;
  logic hreadyout, hresp, pinOut, pinOe, bypass, ioEn, adcEn, cpuEn, flashEn;
  logic rangeSel, extSel, async_timer_external_clock_select;
  logic fuseOut = 1'b1;
  logic fuseDiv8 = 1'b1;
  logic pinOne = 1'b0;
  logic [7:0] factory = 8'h00;
  logic [6:0] fine;
  int failCount = 0;
  int samplesChecked = 0;
  int seed = 50;
  int n, per, hi;

  always #25 clk = ~clk;

  scpc_top dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clockOutputFuse(fuseOut),
    .divideByEightFuse(fuseDiv8), .factoryTrim(factory), .timerOscPinOne(pinOne),
    .clockOutputPinOut(pinOut), .clockOutputPinOe(pinOe), .clockOutputBypass(bypass),
    .ioClkEn(ioEn), .adcClkEn(adcEn), .cpuClkEn(cpuEn), .flashClkEn(flashEn),
    .trimRangeSelect(rangeSel), .trimFineValue(fine),
    .asyncTimerExternalClockSelect(extSel), .timerExtClk(async_timer_external_clock_select));

  // ----------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // expected period in master cycles of a legal divide code
  function automatic logic [31:0] divPeriod(input int code);
    divPeriod = 32'h1 << code;
  endfunction : divPeriod

  task finishTest;
    $display("counts: %0d compared, %0d mismatched", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finishTest

  // ----------------------------------------------------------------
  // bus cycles: values read at an edge are the ones held before it
  // ----------------------------------------------------------------
  task waitReady;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20) begin
      failCount++;
      finishTest();
    end
  endtask : waitReady

  task busXfer(input logic [31:0] a, input logic [31:0] d, input logic w);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= scpc_pkg::HTRANS_NONSEQ;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : busXfer

  // unlock, then load the code; settle two edges so readback shows it
  task setDiv(input logic [31:0] code);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, code, 1'b1);
    repeat (2) @(posedge clk);
  endtask : setDiv

  // one divided period between enable pulses, high time of the pin within it
  task measure;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cpuEn !== 1'b1 && i < 600);
    if (i >= 600) begin
      failCount++;
      finishTest();
    end
    per = 0;
    hi = 0;
    do begin
      @(posedge clk);
      per++;
      hi += int'(pinOut === 1'b1);
      check({29'h0, ioEn, adcEn, flashEn}, {29'h0, {3{cpuEn}}});
    end while (cpuEn !== 1'b1 && per < 600);
    if (per >= 600) begin
      failCount++;
      finishTest();
    end
  endtask : measure

  task doReset(input logic [7:0] f);
    factory <= f;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0, pinOe}, {31'h0, fuseOut});
    check({31'h0, bypass}, 32'h1);
    srst <= 1'b0;
    @(posedge clk);
    check({24'h0, rangeSel, fine}, {24'h0, f});
    busXfer(scpc_pkg::OSC_TRIM_OFFSET, 32'h0, 1'b0);
    check(rd, {24'h0, f});
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, fuseDiv8 ? 32'h3 : 32'h0);
    $display("reset test done");
  endtask : doReset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    v = $random(seed);
    @(posedge clk);
    doReset(v[7:0]);
    // range boundary codes first, since the two ranges overlap there
    // no memory write runs here, so any trim code may be tried
    for (n = 0; n < 8; n++) begin
      v = (n == 0) ? 32'h7f : (n == 1) ? 32'h80 : $random(seed);
      busXfer(scpc_pkg::OSC_TRIM_OFFSET, {24'h0, v[7:0]}, 1'b1);
      busXfer(scpc_pkg::OSC_TRIM_OFFSET, 32'h0, 1'b0);
      check(rd, {24'h0, v[7:0]});
      check({24'h0, rangeSel, fine}, {24'h0, v[7:0]});
    end
    $display("trim test done");
    for (n = 0; n < 9; n++) begin
      setDiv(n);
      busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
      check(rd, n);
      measure();
      measure();
      check(per, divPeriod(n));
      check({31'h0, bypass}, {31'h0, n == 0});
      if (n > 0) check(hi, divPeriod(n) >> 1);
    end
    $display("divide test done");
    v = 32'h9 + ($unsigned($random(seed)) % 7);
    setDiv(v);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h8);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h81, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h2, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h8);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h88);
    repeat (6) @(posedge clk);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h1, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h8);
    // a rewrite of the enable keeps the window open to its last cycle
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h5, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h5);
    // one idle edge more lands past the window; a restart by the rewrite would have kept it inside
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h80, 1'b1);
    @(posedge clk);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h2, 1'b1);
    busXfer(scpc_pkg::CLK_DIV_CTRL_OFFSET, 32'h0, 1'b0);
    check(rd, 32'h5);
    busXfer(32'h0000_0020, 32'h0, 1'b0);
    check(rd, 32'h0);
    $display("unlock test done");
    busXfer(scpc_pkg::ASYNC_TIMER_OFFSET, 32'h1, 1'b1);
    for (n = 0; n < 6; n++) begin
      v = (n == 5) ? 32'h0 : $random(seed);
      if (n == 5) busXfer(scpc_pkg::ASYNC_TIMER_OFFSET, 32'h0, 1'b1);
      pinOne <= (n == 5) ? 1'b1 : v[0];
      repeat (5) @(posedge clk); // pin far slower than a quarter of clk
      check({30'h0, extSel, async_timer_external_clock_select}, (n == 5) ? 32'h0 : {30'h0, 1'b1, v[0]});
    end
    $display("timer clock test done");
    fuseOut <= 1'b0;
    repeat (5) @(posedge clk);
    check({31'h0, pinOe}, 32'h0);
    fuseOut <= 1'b1;
    repeat (5) @(posedge clk);
    check({31'h0, pinOe}, 32'h1);
    fuseDiv8 <= 1'b0;
    v = $random(seed);
    doReset(v[7:0]);
    finishTest();
  end
endmodule : test_system_clock_prescaler_ctrl
